// ---- design/acmp_pkg.sv ----
/*
 * Constants for the auxiliary converter result register and the four
 * digital threshold comparators: register indices and byte addresses,
 * field positions, reset values and channel codes.
 * Assumes an APB slave with 32-bit data, one register per aligned word,
 * byte address equal to four times the register index.
 */
package acmp_pkg;
	localparam int          ADDR_W      = 18;
	localparam int          NUM_CMP     = 4;
	localparam int          DATA_W      = 12;

	localparam logic [15:0] IDX_RESULT  = 16'h402d;
	localparam logic [15:0] IDX_CONTROL = 16'h4030;
	localparam logic [15:0] IDX_CMP1    = 16'h4031;
	localparam logic [15:0] IDX_RSTAT   = 16'h4038;

	localparam logic [17:0] ADDR_RESULT  = {IDX_RESULT, 2'b00};
	localparam logic [17:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};
	localparam logic [17:0] ADDR_CMP1    = {IDX_CMP1, 2'b00};
	localparam logic [17:0] ADDR_RSTAT   = {IDX_RSTAT, 2'b00};

	localparam int          RES_CHAN_LSB = 12;
	localparam int          RES_DATA_MSB = 11;
	localparam int          CTL_STS_LSB  = 8;
	localparam int          CTL_ENA_LSB  = 0;
	localparam int          CMP_SRC_LSB  = 13;
	localparam int          CMP_DIR_BIT  = 12;
	localparam int          RSTAT_FRESH  = 0;
	localparam int          RSTAT_OVRUN  = 1;

	localparam logic [15:0] RESULT_RST  = 16'h0000;
	localparam logic [3:0]  ENABLE_RST  = 4'h0;
	localparam logic [15:0] CMP_RST     = 16'h0000;

	localparam logic [3:0]  CH_BATTERY  = 4'h0;
	localparam logic [3:0]  CH_EXT_ONE  = 4'h1;
	localparam logic [3:0]  CH_EXT_TWO  = 4'h2;
	localparam logic [3:0]  CH_EXT_THR  = 4'h3;
	localparam logic [3:0]  CH_TEMP     = 4'h5;
	localparam logic [3:0]  CH_SUPPLY   = 4'h7;
endpackage

// ---- design/acmp_cmp.sv ----
/*
 * One digital threshold comparator. It checks each completed sample of
 * its selected channel against its threshold and keeps a status bit and
 * a one-cycle flag pulse.
 * Assumes sample_valid is a one-cycle pulse with channel and data valid.
 */
`timescale 1ns/1ns
module acmp_cmp #(
	parameter bit ALLOW_BATTERY = 1'b0
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        sample_valid,
	input  wire logic [3:0]  sample_chan,
	input  wire logic [11:0] sample_data,
	input  wire logic        enable,
	input  wire logic [2:0]  source_sel,
	input  wire logic        direction,
	input  wire logic [11:0] threshold,
	output logic             status,
	output logic             flag
);
	typedef struct packed {
		logic status;
		logic flag;
	} acmp_cmp_state_t;

	acmp_cmp_state_t st_reg;
	acmp_cmp_state_t st_next;

	logic selected;
	logic beyond;

	always_comb begin
		// code 0 is the battery only where allowed, otherwise reserved
		selected = (sample_chan == {1'b0, source_sel}) &&
			((source_sel != 3'h0) || ALLOW_BATTERY);
		// raw unsigned compare: threshold shares the channel coding
		beyond = direction ? (sample_data >= threshold)
			: (sample_data < threshold);
		st_next = st_reg;
		st_next.flag = 1'b0;
		if (sample_valid && enable && selected) begin
			st_next.status = beyond;
			st_next.flag = beyond;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign status = st_reg.status;
	assign flag = st_reg.flag;
endmodule

// ---- design/acmp_top.sv ----
/*
 * Result register and digital comparator block of the auxiliary
 * converter, with its APB register slave.
 * Assumes the converter control delivers each completed sample as a
 * one-cycle conv_done pulse with channel code and 12-bit value, all
 * synchronous to pclk. Interrupt masking and clearing live elsewhere;
 * this block only emits event pulses.
 */
`timescale 1ns/1ns
module acmp_top #(
	parameter int NUM_CMP = acmp_pkg::NUM_CMP,
	parameter int ADDR_W  = acmp_pkg::ADDR_W
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              conv_done,
	input  wire logic [3:0]        conv_channel,
	input  wire logic [11:0]       conv_data,
	output logic                   result_event,
	output logic      [NUM_CMP-1:0] cmp_flag
);
	typedef struct packed {
		logic [3:0]               res_chan;
		logic [11:0]              res_data;
		logic                     res_fresh;
		logic                     res_overrun;
		logic [NUM_CMP-1:0]       cmp_enable;
		logic [NUM_CMP-1:0][15:0] cmp_setup;
		logic                     result_event;
		logic [31:0]              prdata;
		logic                     pready;
		logic                     pslverr;
	} acmp_state_t;

	acmp_state_t st_reg;
	acmp_state_t st_next;

	logic [NUM_CMP-1:0] cmp_status;
	logic [NUM_CMP-1:0] cmp_flag_w;

	// register selector: 0 result, 1 control, 2..5 setups, 6 result status
	typedef enum logic [2:0] {
		ACMP_SEL_RESULT,
		ACMP_SEL_CONTROL,
		ACMP_SEL_CMP1,
		ACMP_SEL_CMP2,
		ACMP_SEL_CMP3,
		ACMP_SEL_CMP4,
		ACMP_SEL_RSTAT,
		ACMP_SEL_NONE
	} acmp_sel_t;

	function automatic acmp_sel_t acmp_decode(input logic [ADDR_W-1:0] addr);
		logic [17:0] a;
		a = 18'(addr);
		if (a == acmp_pkg::ADDR_RESULT) begin
			return ACMP_SEL_RESULT;
		end else if (a == acmp_pkg::ADDR_CONTROL) begin
			return ACMP_SEL_CONTROL;
		end else if (a == acmp_pkg::ADDR_CMP1) begin
			return ACMP_SEL_CMP1;
		end else if (a == acmp_pkg::ADDR_CMP1 + 18'h0_0004) begin
			return ACMP_SEL_CMP2;
		end else if (a == acmp_pkg::ADDR_CMP1 + 18'h0_0008) begin
			return ACMP_SEL_CMP3;
		end else if (a == acmp_pkg::ADDR_CMP1 + 18'h0_000c) begin
			return ACMP_SEL_CMP4;
		end else if (a == acmp_pkg::ADDR_RSTAT) begin
			return ACMP_SEL_RSTAT;
		end else begin
			return ACMP_SEL_NONE;
		end
	endfunction

	// byte-lane merge of a 16-bit register; upper lanes have no storage
	function automatic logic [15:0] acmp_merge(
		input logic [15:0] old,
		input logic [31:0] wdata,
		input logic [3:0]  strb
	);
		logic [15:0] v;
		v = old;
		if (strb[0]) begin
			v[7:0] = wdata[7:0];
		end
		if (strb[1]) begin
			v[15:8] = wdata[15:8];
		end
		return v;
	endfunction

	acmp_sel_t          sel;
	logic               access;
	logic               wr;
	logic               rd;
	logic               rd_result;
	logic [15:0]        ctl_word;
	logic [15:0]        ena_word;
	logic [15:0]        ena_new;
	logic [15:0]        rdata16;
	logic               unmapped;

	always_comb begin
		st_next = st_reg;
		sel = acmp_decode(paddr);
		// one wait state: answer on the second access cycle
		access = psel && penable && !st_reg.pready;
		wr = access && pwrite;
		rd = access && !pwrite;
		unmapped = (sel == ACMP_SEL_NONE);
		rd_result = rd && (sel == ACMP_SEL_RESULT);

		ena_word = 16'h0000;
		ena_word[acmp_pkg::CTL_ENA_LSB +: NUM_CMP] = st_reg.cmp_enable;
		ctl_word = ena_word;
		ctl_word[acmp_pkg::CTL_STS_LSB +: NUM_CMP] = cmp_status;
		ena_new = acmp_merge(ena_word, pwdata, pstrb);

		rdata16 = 16'h0000;
		case (sel)
			ACMP_SEL_RESULT: begin
				rdata16 = {st_reg.res_chan, st_reg.res_data};
			end
			ACMP_SEL_CONTROL: begin
				rdata16 = ctl_word;
			end
			ACMP_SEL_CMP1: begin
				rdata16 = st_reg.cmp_setup[0];
			end
			ACMP_SEL_CMP2: begin
				rdata16 = st_reg.cmp_setup[1];
			end
			ACMP_SEL_CMP3: begin
				rdata16 = st_reg.cmp_setup[2];
			end
			ACMP_SEL_CMP4: begin
				rdata16 = st_reg.cmp_setup[3];
			end
			ACMP_SEL_RSTAT: begin
				rdata16[acmp_pkg::RSTAT_FRESH] = st_reg.res_fresh;
				rdata16[acmp_pkg::RSTAT_OVRUN] = st_reg.res_overrun;
			end
			default: begin
				rdata16 = 16'h0000;
			end
		endcase

		// bus answer
		st_next.pready = access;
		st_next.pslverr = access && unmapped;
		if (rd) begin
			st_next.prdata = {16'h0000, rdata16};
		end else begin
			st_next.prdata = 32'h0000_0000;
		end

		// register writes; the result and status words ignore writes
		if (wr) begin
			case (sel)
				ACMP_SEL_CONTROL: begin
					st_next.cmp_enable = ena_new[acmp_pkg::CTL_ENA_LSB +: NUM_CMP];
				end
				ACMP_SEL_CMP1: begin
					st_next.cmp_setup[0] = acmp_merge(st_reg.cmp_setup[0], pwdata, pstrb);
				end
				ACMP_SEL_CMP2: begin
					st_next.cmp_setup[1] = acmp_merge(st_reg.cmp_setup[1], pwdata, pstrb);
				end
				ACMP_SEL_CMP3: begin
					st_next.cmp_setup[2] = acmp_merge(st_reg.cmp_setup[2], pwdata, pstrb);
				end
				ACMP_SEL_CMP4: begin
					st_next.cmp_setup[3] = acmp_merge(st_reg.cmp_setup[3], pwdata, pstrb);
				end
				default: begin
					st_next.cmp_enable = st_reg.cmp_enable;
				end
			endcase
		end

		// new sample: code and value stored together, raw and unsigned
		if (conv_done) begin
			st_next.res_chan = conv_channel;
			st_next.res_data = conv_data;
		end

		// a sample landing on unread data marks an overrun unless the result is read in that cycle; for fresh, set beats clear
		if (conv_done) begin
			st_next.res_fresh = 1'b1;
		end else if (rd_result) begin
			st_next.res_fresh = 1'b0;
		end
		if (conv_done && st_reg.res_fresh && !rd_result) begin
			st_next.res_overrun = 1'b1;
		end else if (rd_result) begin
			st_next.res_overrun = 1'b0;
		end

		// event rises with the stored result, never ahead of it
		st_next.result_event = conv_done;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg.res_chan <= acmp_pkg::RESULT_RST[15:12];
			st_reg.res_data <= acmp_pkg::RESULT_RST[11:0];
			st_reg.res_fresh <= 1'b0;
			st_reg.res_overrun <= 1'b0;
			st_reg.cmp_enable <= acmp_pkg::ENABLE_RST[NUM_CMP-1:0];
			st_reg.cmp_setup <= {NUM_CMP{acmp_pkg::CMP_RST}};
			st_reg.result_event <= 1'b0;
			st_reg.prdata <= 32'h0000_0000;
			st_reg.pready <= 1'b0;
			st_reg.pslverr <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	// comparators see the very sample being stored
	for (genvar i = 0; i < NUM_CMP; i++) begin : g_cmp
		acmp_cmp #(
			.ALLOW_BATTERY (i == NUM_CMP - 1)
		) u_cmp (
			.pclk          (pclk),
			.presetn       (presetn),
			.sample_valid  (conv_done),
			.sample_chan   (conv_channel),
			.sample_data   (conv_data),
			.enable        (st_reg.cmp_enable[i]),
			.source_sel    (st_reg.cmp_setup[i][acmp_pkg::CMP_SRC_LSB +: 3]),
			.direction     (st_reg.cmp_setup[i][acmp_pkg::CMP_DIR_BIT]),
			.threshold     (st_reg.cmp_setup[i][11:0]),
			.status        (cmp_status[i]),
			.flag          (cmp_flag_w[i])
		);
	end

	assign prdata = st_reg.prdata;
	assign pready = st_reg.pready;
	assign pslverr = st_reg.pslverr;
	assign result_event = st_reg.result_event;
	assign cmp_flag = cmp_flag_w;
endmodule

// ---- verif/acmp_properties.sv ----
/*
 * Port checker for the converter result and comparator block.
 * Assumes it is bound to acmp_top and sees only its ports.
 */
`timescale 1ns/1ns
module acmp_properties #(
	parameter int NUM_CMP = 4,
	parameter int ADDR_W  = 18
) (
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [ADDR_W-1:0]  paddr,
	input wire logic [31:0]        pwdata,
	input wire logic [3:0]         pstrb,
	input wire logic [31:0]        prdata,
	input wire logic               pready,
	input wire logic               pslverr,
	input wire logic               conv_done,
	input wire logic [3:0]         conv_channel,
	input wire logic [11:0]        conv_data,
	input wire logic               result_event,
	input wire logic [NUM_CMP-1:0] cmp_flag
);
	logic [15:0] last_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			last_q <= 16'h0000;
		else if (conv_done)
			last_q <= {conv_channel, conv_data};
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_evt; conv_done |=> result_event; endproperty
	a_evt: assert property (p_evt) else $error("no result event");
	property p_quiet; !conv_done |=> !result_event && cmp_flag == '0; endproperty
	a_quiet: assert property (p_quiet) else $error("event without sample");
	property p_flag; cmp_flag != '0 |-> result_event; endproperty
	a_flag: assert property (p_flag) else $error("flag off sample");
	property p_ans; psel && penable && !pready |=> pready; endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_hi; pready |-> prdata[31:16] == 16'h0000; endproperty
	a_hi: assert property (p_hi) else $error("upper read bits set");
	property p_idle; !pready |-> prdata == 32'h0000_0000 && !pslverr; endproperty
	a_idle: assert property (p_idle) else $error("data outside answer");
	property p_err; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
	a_err: assert property (p_err) else $error("bad error answer");
	property p_rd;
		pready && !pwrite && !pslverr && paddr == acmp_pkg::ADDR_RESULT && !$past(conv_done)
			|-> prdata[15:0] == last_q;
	endproperty
	a_rd: assert property (p_rd) else $error("result read mismatch");

	c_evt: cover property (result_event);
	c_flag: cover property (cmp_flag != '0);
	c_err: cover property (pslverr);
endmodule

bind acmp_top acmp_properties #(.NUM_CMP(NUM_CMP), .ADDR_W(ADDR_W)) chk_u (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .conv_done(conv_done), .conv_channel(conv_channel),
	.conv_data(conv_data), .result_event(result_event), .cmp_flag(cmp_flag)
);

// ---- verif/acmp_conv_model.sv ----
/*
 * Converter control model: one sample pulse per trigger.
 * Assumes go is a one-cycle pulse from the bench.
 */
`timescale 1ns/1ns
module acmp_conv_model (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        go,
	input wire logic [3:0]  go_chan,
	input wire logic [11:0] go_data,
	output logic            conv_done,
	output logic [3:0]      conv_channel,
	output logic [11:0]     conv_data
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_done <= 1'b0;
			conv_channel <= 4'h0;
			conv_data <= 12'h000;
		end else begin
			conv_done <= go;
			// outside a sample the lines toggle, so stale values match only every second cycle
			conv_channel <= go ? go_chan : ~conv_channel;
			conv_data <= go ? go_data : ~conv_data;
		end
	end
endmodule

// ---- verif/adc_result_and_threshold_compare_test.sv ----
/*
 * Self-checking bench: APB master tasks, converter model, scenarios.
 * Assumes acmp_top, acmp_pkg and the converter model are compiled first.
 */
`timescale 1ns/1ns
module adc_result_and_threshold_compare_test;
	localparam logic [17:0] A_RES = acmp_pkg::ADDR_RESULT;
	localparam logic [17:0] A_CTL = acmp_pkg::ADDR_CONTROL;
	localparam logic [17:0] A_C1  = acmp_pkg::ADDR_CMP1;
	localparam logic [17:0] A_RST = acmp_pkg::ADDR_RSTAT;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        go, conv_done, result_event;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  go_chan, conv_channel, cmp_flag, fl, pstrb;
	logic [11:0] go_data, conv_data;
	int          n_mismatch, cmp_count, cyc;

	acmp_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .conv_done(conv_done),
		.conv_channel(conv_channel), .conv_data(conv_data),
		.result_event(result_event), .cmp_flag(cmp_flag));
	acmp_conv_model conv_u (.pclk(pclk), .presetn(presetn), .go(go), .go_chan(go_chan),
		.go_data(go_data), .conv_done(conv_done), .conv_channel(conv_channel),
		.conv_data(conv_data));

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	task automatic wrap_up;
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask

	task automatic apb(input logic w, input logic [17:0] a, input logic [15:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [17:0] a, input logic [15:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd(input logic [17:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 16'h0000, r, e);
		chk(r, x);
	endtask

	task automatic smp(input logic [3:0] c, input logic [11:0] d);
		go <= 1'b1;
		go_chan <= c;
		go_data <= d;
		@(posedge pclk);
		go <= 1'b0;
		do @(posedge pclk); while (result_event !== 1'b1);
		fl = cmp_flag;
	endtask

	task automatic t_reset;
		rd(A_RES, 32'h0000_0000);
		rd(A_CTL, 32'h0000_0000);
		rd(A_C1 + 18'h0000c, 32'h0000_0000);
	endtask

	task automatic t_result;
		logic [3:0] codes [5] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h7};
		foreach (codes[i]) begin
			smp(codes[i], 12'h9a0 + 12'(i));
			rd(A_RES, {16'h0000, codes[i], 12'h9a0 + 12'(i)});
		end
		rd(A_RST, 32'h0000_0000);
		smp(4'h1, 12'h123);
		smp(4'h7, 12'hfff);
		// second sample lands on unread data: fresh and overrun both set
		rd(A_RST, 32'h0000_0003);
		rd(A_RES, 32'h0000_7fff);
		rd(A_RST, 32'h0000_0000);
	endtask

	task automatic t_cmp;
		wr(A_C1, 16'h3800);
		wr(A_C1 + 18'h00004, 16'h2800);
		wr(A_CTL, 16'h0003);
		smp(4'h1, 12'h800);
		chk(fl, 4'b0001);
		rd(A_CTL, 32'h0000_0103);
		smp(4'h1, 12'h7ff);
		chk(fl, 4'b0010);
		smp(4'h2, 12'hfff);
		chk(fl, 4'b0000);
		wr(A_C1 + 18'h00004, 16'h2000);
		rd(A_CTL, 32'h0000_0203);
		wr(A_CTL, 16'h0001);
		smp(4'h1, 12'h000);
		rd(A_CTL, 32'h0000_0201);
	endtask

	task automatic t_batt;
		wr(A_C1, 16'h1000);
		wr(A_C1 + 18'h0000c, 16'h1000);
		wr(A_CTL, 16'h0009);
		smp(4'h0, 12'h400);
		chk(fl, 4'b1000);
		rd(A_CTL, 32'h0000_0a09);
	endtask

	task automatic t_err;
		logic [31:0] r;
		logic        e;
		apb(1'b0, 18'h00010, 16'h0000, r, e);
		chk({31'h0, e}, 32'h0000_0001);
		wr(A_RES, 16'hffff);
		rd(A_RES, 32'h0000_0400);
		// only the low byte lane is written
		pstrb <= 4'h1;
		wr(A_C1 + 18'h00008, 16'hffff);
		pstrb <= 4'hf;
		rd(A_C1 + 18'h00008, 32'h0000_00ff);
	endtask

	initial begin
		{psel, penable, pwrite, go} = 4'h0;
		paddr = 18'h00000;
		pwdata = 32'h0000_0000;
		pstrb = 4'hf;
		go_chan = 4'h0;
		go_data = 12'h000;
		presetn = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_result();
		t_cmp();
		t_batt();
		t_err();
		wrap_up();
	end
endmodule
